//--- hw/tx_seq_map.svh
// Offsets, lengths, field positions and timing counts of the transmit sequencer.
// Assumes the 40 MHz block clock and a 1920 kHz modulation data strobe.
`ifndef TX_SEQ_MAP_SVH
`define TX_SEQ_MAP_SVH

`define CLK_KHZ          40000
`define STROBE_KHZ       1920
`define TICKS_PER_SEC    1920000
`define CHIP_SAMPLES     8
`define UNCODED_US       66
`define LEN_CODE16       (16 * `CHIP_SAMPLES)
`define LEN_UNCODED      ((`UNCODED_US * `STROBE_KHZ + 999) / 1000)
`define LEN_CODE64       (64 * `CHIP_SAMPLES)
`define LEN_CODE128      (128 * `CHIP_SAMPLES)
`define BASE_CODE1       11'h000
`define BASE_CODE2       11'h080
`define BASE_UNCODED     11'h100
`define BASE_CODE64      11'h180
`define BASE_CODE128     11'h380
`define PROFILE_HOLD_NS  500
`define PROFILE_HOLD_CYC ((`PROFILE_HOLD_NS * `CLK_KHZ + 999999) / 1000000)
`define ZERO_PROFILE     2'h3
`define FLAG_REF         0
`define FLAG_IRQ         1
`define FLAG_TX          2
`define RX_NIBBLES       3'h4

`endif

//--- hw/tx_seq_pkg.sv
// Types shared by the transmit sequencer files.
// Numeric constants live in tx_seq_map.svh.
package tx_seq_pkg;

	typedef enum logic [2:0] {
		WAVE_CODE1   = 3'h0,
		WAVE_CODE2   = 3'h1,
		WAVE_UNCODED = 3'h2,
		WAVE_CODE64  = 3'h3,
		WAVE_CODE128 = 3'h4
	} wave_sel_e;

	typedef enum logic [1:0] {
		PH_LINEAR  = 2'h0,
		PH_PLUS90  = 2'h1,
		PH_MINUS90 = 2'h2
	} phase_mode_e;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_PRIME = 3'h2,
		ST_PLAY  = 3'h4
	} play_state_e;

endpackage

//--- hw/iq_fifo.sv
// Flip-flop FIFO for prefetched I/Q words.
// Assumes one clock; the writer honours in_ready_o.
`timescale 1ns/1ps

module iq_fifo #(
	parameter int W     = 24,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	// Fill side
	input  wire logic         in_valid_i,
	input  wire logic [W-1:0] in_data_i,
	output logic              in_ready_o,
	// Drain side
	output logic              out_valid_o,
	output logic [W-1:0]      out_data_o,
	input  wire logic         out_ready_i
);

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0]  mem_r [DEPTH];
	logic [PW-1:0] wr_r;
	logic [PW-1:0] rd_r;
	logic [CW-1:0] cnt_r;
	logic          push;
	logic          pop;

	assign in_ready_o  = (cnt_r != CW'(DEPTH));
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o  = mem_r[rd_r];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_ready_i & out_valid_o;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wr_r] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_r <= (wr_r == PW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= (rd_r == PW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop && !push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end

endmodule

//--- hw/tx_timing_modulation_sequencer.sv
// Timing and modulation sequencer of the two-channel transmitter.
// Assumes flash answers a read one cycle after flash_rd_o; strobe and PPS arrive asynchronously.
`timescale 1ns/1ps
`include "tx_seq_map.svh"

module tx_timing_modulation_sequencer #(
	parameter int DW            = 12,
	parameter int AW            = 11,
	parameter int TW            = 21,
	parameter int TM_DEPTH      = 16,
	parameter int FIFO_DEPTH    = 32,
	parameter int TICKS_PER_SEC = `TICKS_PER_SEC
) (
	// Clock and reset
	input  wire logic            clk_i,
	input  wire logic            rst_b_i,
	// Up-converter link
	input  wire logic            modulation_data_strobe_i,
	output logic [2*DW-1:0]      ch_i_o,
	output logic [2*DW-1:0]      ch_q_o,
	output logic [1:0]           profile_sel_o,
	output logic                 ref_pulse_o,
	// Pulse per second, after the inverting buffer
	input  wire logic            pps_b_i,
	// Waveform flash
	output logic                 flash_rd_o,
	output logic [AW-1:0]        flash_addr_o,
	input  wire logic [2*DW-1:0] flash_data_i,
	// Control
	input  wire logic [2:0]      wave_sel_i,
	input  wire logic            oblique_i,
	input  wire logic [1:0]      phase_mode_i,
	input  wire logic [1:0]      op_profile_i,
	input  wire logic            tm_wr_i,
	input  wire logic [3:0]      tm_index_i,
	input  wire logic [TW-1:0]   tm_time_i,
	input  wire logic [2:0]      tm_flags_i,
	output logic                 irq_o,
	output logic                 tx_active_o,
	output logic                 wave_refused_o,
	// Pre-processor nibble path
	input  wire logic [15:0]     rx_data_i,
	input  wire logic            rx_valid_i,
	output logic                 rx_ready_o,
	output logic [3:0]           nibble_o,
	output logic                 nibble_strobe_o
);

	localparam int HOLD = `PROFILE_HOLD_CYC;
	localparam int HW   = $clog2(HOLD + 1);

	logic                   strb_s1_r, strb_s2_r, strb_s3_r;
	logic                   pps_s1_r, pps_s2_r, pps_s3_r;
	logic                   tick;
	logic                   pps_lead;
	logic [TW-1:0]          sec_cnt_r;
	logic [TW-1:0]          tm_time_r [TM_DEPTH];
	logic [2:0]             tm_flags_r [TM_DEPTH];
	logic [TM_DEPTH-1:0]    tm_hit;
	logic [2:0]             fire;
	logic                   ref_pulse_r, irq_r;
	logic [1:0]             prof_r;
	logic [HW-1:0]          hold_r;
	tx_seq_pkg::play_state_e st_r;
	logic [AW-1:0]          play_left_r;
	logic                   tx_active_r, refused_r;
	logic                   start_v, legal;
	logic [AW-1:0]          fetch_left_r;
	logic [AW-1:0]          addr_r;
	logic                   flash_rd_r, rd_d_r, issue;
	logic                   fifo_in_ready, fifo_out_valid, pop;
	logic [2*DW-1:0]        fifo_data;
	logic [DW-1:0]          w_i, w_q;
	logic [DW-1:0]          ch_i_r [2];
	logic [DW-1:0]          ch_q_r [2];
	logic                   out_upd_r;
	logic [15:0]            nib_sr_r;
	logic [2:0]             nib_left_r, nib_left_nxt;
	logic [3:0]             nibble_r;
	logic                   nib_strobe_r, rx_ready_r, accept;

	function automatic logic [AW-1:0] wave_base(input logic [2:0] sel);
		case (sel)
			tx_seq_pkg::WAVE_CODE2:   wave_base = AW'(`BASE_CODE2);
			tx_seq_pkg::WAVE_UNCODED: wave_base = AW'(`BASE_UNCODED);
			tx_seq_pkg::WAVE_CODE64:  wave_base = AW'(`BASE_CODE64);
			tx_seq_pkg::WAVE_CODE128: wave_base = AW'(`BASE_CODE128);
			default:                  wave_base = AW'(`BASE_CODE1);
		endcase
	endfunction

	function automatic logic [AW-1:0] wave_len(input logic [2:0] sel);
		case (sel)
			tx_seq_pkg::WAVE_UNCODED: wave_len = AW'(`LEN_UNCODED);
			tx_seq_pkg::WAVE_CODE64:  wave_len = AW'(`LEN_CODE64);
			tx_seq_pkg::WAVE_CODE128: wave_len = AW'(`LEN_CODE128);
			default:                  wave_len = AW'(`LEN_CODE16);
		endcase
	endfunction

	function automatic logic [DW-1:0] neg(input logic [DW-1:0] x);
		neg = ~x + 1'b1;
	endfunction

	// strobe from master-clock domain
	// The strobe comes from the up-converter's master clock, so it is resynchronised here.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{strb_s3_r, strb_s2_r, strb_s1_r} <= 3'h0;
		end else begin
			{strb_s3_r, strb_s2_r, strb_s1_r} <= {strb_s2_r, strb_s1_r, modulation_data_strobe_i};
		end
	end

	assign tick = strb_s2_r & ~strb_s3_r;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{pps_s3_r, pps_s2_r, pps_s1_r} <= 3'h7;
		end else begin
			{pps_s3_r, pps_s2_r, pps_s1_r} <= {pps_s2_r, pps_s1_r, pps_b_i};
		end
	end

	assign pps_lead = pps_s3_r & ~pps_s2_r;

	// second counter
	// With no PPS the counter free-runs and wraps, so the sounder keeps working.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sec_cnt_r <= '0;
		end else if (pps_lead) begin
			sec_cnt_r <= '0;
		end else if (tick) begin
			sec_cnt_r <= (sec_cnt_r == TW'(TICKS_PER_SEC - 1)) ? '0 : sec_cnt_r + 1'b1;
		end
	end

	for (genvar k = 0; k < TM_DEPTH; k++) begin : gen_tm
		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				tm_time_r[k]  <= '0;
				tm_flags_r[k] <= 3'h0;
			end else if (tm_wr_i && tm_index_i == 4'(k)) begin
				tm_time_r[k]  <= tm_time_i;
				tm_flags_r[k] <= tm_flags_i;
			end
		end
		assign tm_hit[k] = (tm_time_r[k] == sec_cnt_r);
	end

	always_comb begin
		fire = 3'h0;
		for (int k = 0; k < TM_DEPTH; k++) begin
			if (tm_hit[k] && tick) begin
				fire = fire | tm_flags_r[k];
			end
		end
	end

	// reference pulse and interrupt
	// Both stand for exactly one strobe period.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ref_pulse_r <= 1'b0;
			irq_r       <= 1'b0;
		end else if (tick) begin
			ref_pulse_r <= fire[`FLAG_REF];
			irq_r       <= fire[`FLAG_IRQ];
		end
	end

	// zero-frequency profile
	// The up-converter clears its own phase; we only hold the zero profile long enough.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prof_r <= 2'h0;
			hold_r <= '0;
		end else if (fire[`FLAG_REF]) begin
			prof_r <= `ZERO_PROFILE;
			// Count ends at zero, so the zero profile stands exactly HOLD cycles
			hold_r <= HW'(HOLD - 1);
		end else if (hold_r != '0) begin
			hold_r <= hold_r - 1'b1;
		end else begin
			prof_r <= op_profile_i;
		end
	end

	assign legal   = oblique_i | ~((wave_sel_i == tx_seq_pkg::WAVE_CODE64) |
	                               (wave_sel_i == tx_seq_pkg::WAVE_CODE128));
	assign start_v = fire[`FLAG_TX] & (st_r == tx_seq_pkg::ST_IDLE);
	assign pop     = tick & (st_r == tx_seq_pkg::ST_PLAY) & (play_left_r != '0) & fifo_out_valid;

	// pulse playback
	// A start that arrives during a pulse is ignored.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r        <= tx_seq_pkg::ST_IDLE;
			play_left_r <= '0;
			tx_active_r <= 1'b0;
			refused_r   <= 1'b0;
		end else begin
			if (start_v) begin
				refused_r <= ~legal;
			end
			case (st_r)
				tx_seq_pkg::ST_IDLE: begin
					if (start_v && legal) begin
						st_r        <= tx_seq_pkg::ST_PRIME;
						play_left_r <= wave_len(wave_sel_i);
					end
				end
				tx_seq_pkg::ST_PRIME: begin
					if (tick) begin
						st_r        <= tx_seq_pkg::ST_PLAY;
						tx_active_r <= 1'b1;
					end
				end
				tx_seq_pkg::ST_PLAY: begin
					if (tick) begin
						if (play_left_r == '0) begin
							st_r        <= tx_seq_pkg::ST_IDLE;
							tx_active_r <= 1'b0;
						end else begin
							play_left_r <= play_left_r - 1'b1;
						end
					end
				end
				default: begin
					st_r <= tx_seq_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// prefetch from flash
	// One read in flight at a time, so a word never arrives at a full FIFO.
	assign issue = (st_r != tx_seq_pkg::ST_IDLE) & (fetch_left_r != '0) & fifo_in_ready &
	               ~flash_rd_r & ~rd_d_r;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fetch_left_r <= '0;
			addr_r       <= '0;
			flash_rd_r   <= 1'b0;
			rd_d_r       <= 1'b0;
		end else begin
			flash_rd_r <= issue;
			rd_d_r     <= flash_rd_r;
			if (start_v && legal) begin
				addr_r       <= wave_base(wave_sel_i);
				fetch_left_r <= wave_len(wave_sel_i);
			end else begin
				if (issue) begin
					fetch_left_r <= fetch_left_r - 1'b1;
				end
				if (flash_rd_r) begin
					addr_r <= addr_r + 1'b1;
				end
			end
		end
	end

	iq_fifo #(
		.W     (2 * DW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_b_i     (rst_b_i),
		.in_valid_i  (rd_d_r),
		.in_data_i   (flash_data_i),
		.in_ready_o  (fifo_in_ready),
		.out_valid_o (fifo_out_valid),
		.out_data_o  (fifo_data),
		.out_ready_i (pop)
	);

	// I word high, Q word low
	assign w_i = fifo_data[2*DW-1:DW];
	assign w_q = fifo_data[DW-1:0];

	for (genvar c = 0; c < 2; c++) begin : gen_ch
		logic [DW-1:0] ri, rq;
		always_comb begin
			ri = w_i;
			rq = w_q;
			if (c == 1) begin
				case (phase_mode_i)
					tx_seq_pkg::PH_PLUS90: begin
						ri = neg(w_q);
						rq = w_i;
					end
					tx_seq_pkg::PH_MINUS90: begin
						ri = w_q;
						rq = neg(w_i);
					end
					default: begin
						ri = w_i;
						rq = w_q;
					end
				endcase
			end
		end
		// Underrun sends zero rather than a stale sample
		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				ch_i_r[c] <= '0;
				ch_q_r[c] <= '0;
			end else if (tick && st_r == tx_seq_pkg::ST_PLAY) begin
				ch_i_r[c] <= pop ? ri : '0;
				ch_q_r[c] <= pop ? rq : '0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			out_upd_r <= 1'b0;
		end else begin
			out_upd_r <= pop;
		end
	end

	assign accept = rx_valid_i & rx_ready_r;

	always_comb begin
		nib_left_nxt = nib_left_r;
		if (accept) begin
			nib_left_nxt = `RX_NIBBLES;
		end else if (tick && nib_left_r != 3'h0) begin
			nib_left_nxt = nib_left_r - 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			nib_sr_r     <= 16'h0;
			nib_left_r   <= 3'h0;
			nibble_r     <= 4'h0;
			nib_strobe_r <= 1'b0;
			rx_ready_r   <= 1'b0;
		end else begin
			nib_left_r   <= nib_left_nxt;
			rx_ready_r   <= (nib_left_nxt == 3'h0);
			nib_strobe_r <= 1'b0;
			if (accept) begin
				nib_sr_r <= rx_data_i;
			end else if (tick && nib_left_r != 3'h0) begin
				nibble_r     <= nib_sr_r[15:12];
				nib_sr_r     <= {nib_sr_r[11:0], 4'h0};
				nib_strobe_r <= 1'b1;
			end
		end
	end

	assign ch_i_o          = {ch_i_r[1], ch_i_r[0]};
	assign ch_q_o          = {ch_q_r[1], ch_q_r[0]};
	assign profile_sel_o   = prof_r;
	assign ref_pulse_o     = ref_pulse_r;
	assign irq_o           = irq_r;
	assign flash_rd_o      = flash_rd_r;
	assign flash_addr_o    = addr_r;
	assign tx_active_o     = tx_active_r;
	assign wave_refused_o  = refused_r;
	assign rx_ready_o      = rx_ready_r;
	assign nibble_o        = nibble_r;
	assign nibble_strobe_o = nib_strobe_r;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	pps_realign_a: assert property (pps_lead |=> sec_cnt_r == '0)
		else $error("second counter not realigned on PPS");
	sec_wrap_a: assert property (tick && !pps_lead && sec_cnt_r == TW'(TICKS_PER_SEC - 1) |=> sec_cnt_r == '0)
		else $error("second counter did not wrap");
	ref_hold_a: assert property (fire[`FLAG_REF] |=> (ref_pulse_o && profile_sel_o == `ZERO_PROFILE) [*8])
		else $error("zero profile or reference pulse too short");
	irq_follow_a: assert property ((tick && fire[`FLAG_IRQ]) || (irq_o && !tick) |=> irq_o)
		else $error("interrupt dropped early");
	oblique_only_a: assert property (start_v && !oblique_i && wave_sel_i == tx_seq_pkg::WAVE_CODE64
		|=> st_r == tx_seq_pkg::ST_IDLE && wave_refused_o)
		else $error("long code started outside oblique mode");
	fetch_step_a: assert property (flash_rd_o |=> !flash_rd_o && flash_addr_o == $past(flash_addr_o) + 1'b1)
		else $error("flash address did not advance");
	iq_pair_a: assert property (pop |=> ch_i_o[DW-1:0] == $past(w_i) && ch_q_o[DW-1:0] == $past(w_q))
		else $error("I/Q pair not delivered");
	quad_phase_a: assert property (out_upd_r && $past(phase_mode_i) == tx_seq_pkg::PH_PLUS90
		|-> ch_q_o[2*DW-1:DW] == ch_i_o[DW-1:0])
		else $error("channel 1 not in quadrature");
	nibble_out_a: assert property (tick && !accept && nib_left_r != 3'h0
		|=> nibble_strobe_o && nibble_o == $past(nib_sr_r[15:12]))
		else $error("nibble not sent on strobe");
	prime_play_a: assert property (st_r == tx_seq_pkg::ST_PRIME && tick |=> tx_active_o)
		else $error("pulse did not start");

	start_c: cover property (start_v && legal ##1 st_r == tx_seq_pkg::ST_PRIME);
	refuse_c: cover property (start_v && !legal);
	realign_c: cover property (pps_lead && sec_cnt_r != '0);
	nibble_c: cover property (accept ##[1:200] nibble_strobe_o);

endmodule

//--- testbench/upconv_model.sv
// Far-side model: up-converter strobe source with its carrier phase, and the waveform flash.
// Assumes the bench clock; flash answers from the read strobe through the following cycle.
`timescale 1ns/1ps
`include "tx_seq_map.svh"

module upconv_model (
	// Clock
	input  wire logic        clk_i,
	// Up-converter side
	output logic             strobe_o,
	input  wire logic [1:0]  profile_sel_i,
	// Flash side
	input  wire logic        flash_rd_i,
	input  wire logic [10:0] flash_addr_i,
	output logic [23:0]      flash_data_o
);
	logic [31:0] phase_acc = '0;
	logic        rd_d      = 1'b0;
	logic [10:0] addr_d    = '0;

	function automatic logic [23:0] word(input logic [10:0] a);
		return {1'b0, a, 1'b1, ~a};
	endfunction

	// strobe runs free
	// Offset half period keeps its edges away from the block clock edges
	initial begin
		strobe_o = 1'b0;
		#37;
		forever #100 strobe_o = ~strobe_o;
	end

	always @(posedge clk_i) begin
		if (profile_sel_i == `ZERO_PROFILE)
			phase_acc <= '0;
		else
			phase_acc <= phase_acc + 32'h1;
	end

	always @(posedge clk_i) begin
		rd_d   <= flash_rd_i;
		addr_d <= flash_addr_i;
	end

	// Released bus shows the inverse of the last word so stale data cannot pass
	assign flash_data_o = flash_rd_i ? word(flash_addr_i) : (rd_d ? word(addr_d) : ~word(addr_d));
endmodule

//--- testbench/tb.sv
// Self-checking bench of the transmit sequencer: timing events, playback of each waveform, nibble path.
// Assumes upconv_model.sv as far side; expected samples follow the model's flash pattern.
`timescale 1ns/1ps
`include "tx_seq_map.svh"

module tb;
	localparam int LIMIT = 60000;

	logic        clk_i, rst_b_i, strobe, pps_b_i, ref_pulse, flash_rd, oblique, tm_wr, irq;
	logic        tx_active, wave_refused, rx_valid, rx_ready, nibble_strobe;
	logic [23:0] ch_i, ch_q, flash_data;
	logic [10:0] flash_addr;
	logic [20:0] tm_time;
	logic [15:0] rx_data;
	logic [3:0]  tm_index, nibble;
	logic [2:0]  wave_sel, tm_flags;
	logic [1:0]  profile_sel, phase_mode, op_profile, mode;
	logic [47:0] sq[$];
	logic [47:0] last_out = '0;
	logic [3:0]  nq[$];
	int          n_mismatch, samples_checked, cycles, ticks, n, sel;
	int          bases[5] = '{`BASE_CODE1, `BASE_CODE2, `BASE_UNCODED, `BASE_CODE64, `BASE_CODE128};
	int          lens[5]  = '{`LEN_CODE16, `LEN_CODE16, `LEN_UNCODED, `LEN_CODE64, `LEN_CODE128};
	int          sel_t[7] = '{0, 3, 1, 4, 2, 3, 4};

	tx_timing_modulation_sequencer #(.TICKS_PER_SEC(200)) DUT (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .modulation_data_strobe_i(strobe), .ch_i_o(ch_i), .ch_q_o(ch_q),
		.profile_sel_o(profile_sel), .ref_pulse_o(ref_pulse), .pps_b_i(pps_b_i), .flash_rd_o(flash_rd),
		.flash_addr_o(flash_addr), .flash_data_i(flash_data), .wave_sel_i(wave_sel), .oblique_i(oblique),
		.phase_mode_i(phase_mode), .op_profile_i(op_profile), .tm_wr_i(tm_wr), .tm_index_i(tm_index),
		.tm_time_i(tm_time), .tm_flags_i(tm_flags), .irq_o(irq), .tx_active_o(tx_active),
		.wave_refused_o(wave_refused), .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
		.nibble_o(nibble), .nibble_strobe_o(nibble_strobe));

	upconv_model far_side (
		.clk_i(clk_i), .strobe_o(strobe), .profile_sel_i(profile_sel), .flash_rd_i(flash_rd),
		.flash_addr_i(flash_addr), .flash_data_o(flash_data));

	function automatic logic [47:0] expect_word(input logic [10:0] a, input logic [1:0] m);
		logic [11:0] i0, q0, i1, q1;
		i0 = {1'b0, a};
		q0 = {1'b1, ~a};
		i1 = (m == 2'h1) ? -q0 : ((m == 2'h2) ? q0 : i0);
		q1 = (m == 2'h1) ? i0 : ((m == 2'h2) ? -i0 : q0);
		return {i1, i0, q1, q0};
	endfunction

	task automatic check(input logic [47:0] got, input logic [47:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic close_out();
		$display("Counts: %0d compared, %0d mismatched", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic tm_write(input logic [3:0] idx, input logic [20:0] t, input logic [2:0] f);
		@(posedge clk_i);
		tm_wr    <= 1'b1;
		tm_index <= idx;
		tm_time  <= t;
		tm_flags <= f;
		@(posedge clk_i);
		tm_wr <= 1'b0;
	endtask

	task automatic send_rx(input logic [15:0] d);
		rx_valid <= 1'b1;
		rx_data  <= d;
		for (int k = 0; k < 200; k++) begin
			@(posedge clk_i);
			if (rx_ready === 1'b1)
				break;
		end
		for (int m = 3; m >= 0; m--)
			nq.push_back(d[m*4 +: 4]);
	endtask

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	always @(posedge strobe)
		ticks++;

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_mismatch++;
			$display("Error at %0t ns: got %h expected %h cycles", $time, cycles, LIMIT);
			close_out();
		end
	end

	// Scoreboard: oldest note is compared whenever a new sample or nibble shows
	always @(posedge clk_i) begin
		if ({ch_i, ch_q} !== last_out && {ch_i, ch_q} !== 48'h0)
			check({ch_i, ch_q}, sq.size() ? sq.pop_front() : 48'h0);
		last_out <= {ch_i, ch_q};
		if (nibble_strobe === 1'b1)
			check({44'h0, nibble}, {44'h0, nq.size() ? nq.pop_front() : ~nibble});
	end

	initial begin
		rst_b_i = 1'b0;
		pps_b_i = 1'b1;
		{wave_sel, oblique, phase_mode, op_profile, tm_wr, tm_index, tm_time, tm_flags} = '0;
		{rx_data, rx_valid} = '0;
		void'($urandom(27388));
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		op_profile <= 2'($urandom % 3);
		repeat (2) @(posedge clk_i);
		check({47'h0, rx_ready}, 48'h1);
		check({46'h0, profile_sel}, {46'h0, op_profile});
		$display("Test reset done");

		for (int w = 0; w < 3; w++)
			send_rx(16'($urandom));
		rx_valid <= 1'b0;
		for (int k = 0; k < 400 && nq.size() > 0; k++) @(posedge clk_i);
		check(48'(nq.size()), 48'h0);
		$display("Test nibbles done");

		tm_write(4'h0, 21'd5, 3'h3);
		for (int r = 0; r < 2; r++) begin
			repeat (40 + 13 * r) @(posedge clk_i);
			pps_b_i <= 1'b0;
			ticks = 0;
			for (int k = 0; k < 200 && ref_pulse !== 1'b1; k++) @(posedge clk_i);
			check({47'h0, ticks inside {[5:7]}}, 48'h1);
			check({46'h0, irq, ref_pulse}, 48'h3);
			n = 0;
			while (profile_sel === `ZERO_PROFILE && n < 100) begin
				@(posedge clk_i);
				n++;
			end
			check(48'(n), 48'(`PROFILE_HOLD_CYC));
			check(48'(far_side.phase_acc), 48'h0);
			check({46'h0, profile_sel}, {46'h0, op_profile});
			for (int k = 0; k < 20 && ref_pulse === 1'b1; k++) @(posedge clk_i);
			check({47'h0, irq}, 48'h0);
			pps_b_i <= 1'b1;
			$display("Test reference pulse %0d done", r);
		end

		for (int c = 0; c < 7; c++) begin
			sel  = sel_t[c];
			// Legal cases walk through every phase mode
			mode = 2'(c % 3 + c / 5);
			@(posedge clk_i);
			wave_sel   <= 3'(sel);
			oblique    <= (c >= 5);
			phase_mode <= mode;
			if (c != 1 && c != 3)
				for (int k = 0; k < lens[sel]; k++)
					sq.push_back(expect_word(11'(bases[sel] + k), mode));
			tm_write(4'h1, 21'd10, 3'h4);
			// The refused flag may still stand from an earlier case, so wait for the awaited outcome only
			for (int k = 0; k < 2000 && ((c == 1 || c == 3) ? wave_refused !== 1'b1 : tx_active !== 1'b1); k++)
				@(posedge clk_i);
			check({46'h0, tx_active, wave_refused}, (c == 1 || c == 3) ? 48'h1 : 48'h2);
			tm_write(4'h1, 21'd10, 3'h0);
			for (int k = 0; k < 9000 && tx_active === 1'b1; k++) @(posedge clk_i);
			repeat (20) @(posedge clk_i);
			check(48'(sq.size()), 48'h0);
			$display("Test playback case %0d done", c);
		end
		close_out();
	end
endmodule
